// >>> rtl/ipw_pkg.sv
// constants for the indexed-port watchdog
package ipw_pkg;
  localparam logic [15:0] INDEX_PORT     = 16'h002e;
  localparam logic [15:0] DATA_PORT      = 16'h002f;
  localparam logic [7:0]  KEY_UNLOCK     = 8'h87;
  localparam logic [7:0]  KEY_LOCK       = 8'haa;
  localparam logic [7:0]  REG_LDN        = 8'h07;
  localparam logic [7:0]  REG_ACTIVATE   = 8'h30;
  localparam logic [7:0]  REG_UNIT       = 8'hf0;
  localparam logic [7:0]  REG_COUNT      = 8'hf1;
  localparam logic [7:0]  REG_CTRL       = 8'hf2;
  localparam logic [7:0]  LDN_WDT        = 8'h08;
  localparam logic [7:0]  ACT_ENABLE     = 8'h01;
  localparam int          UNIT_BIT       = 3;
  localparam int          MOUSE_BIT      = 7;
  localparam int          KBD_BIT        = 6;
  localparam int          FORCE_BIT      = 5;
  localparam int          STATUS_BIT     = 4;
  localparam logic [7:0]  RST_LDN        = 8'h00;
  localparam logic [7:0]  RST_ACTIVATE   = 8'h00;
  localparam logic [7:0]  RST_UNIT       = 8'h00;
  localparam logic [7:0]  RST_COUNT      = 8'h00;
  localparam logic [7:0]  RD_NONE        = 8'h00;
  localparam longint      SECOND_NS      = 1000000000;
  localparam longint      CLK_PERIOD_NS  = 100;
  localparam int          CYCLES_PER_SEC = int'(SECOND_NS / CLK_PERIOD_NS);
  localparam int          SECS_PER_MIN   = 60;

  typedef enum logic [2:0] {
    LK_LOCKED   = 3'b001,
    LK_KEY1     = 3'b010,
    LK_UNLOCKED = 3'b100
  } ipw_lock_t;
endpackage : ipw_pkg

// >>> rtl/ipw_tick_if.sv
// time-base signals between watchdog core and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface ipw_tick_if;
  logic restart;
  logic sec_tick;
  logic min_tick;
  modport core (output restart, input sec_tick, input min_tick);
  modport presc (input restart, output sec_tick, output min_tick);
endinterface : ipw_tick_if
`default_nettype wire

// >>> rtl/ipw_prescaler.sv
// second and minute tick generator
`timescale 1ns/1ps
`default_nettype none
module ipw_prescaler #(
  parameter int CYCLES_PER_SEC = ipw_pkg::CYCLES_PER_SEC
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  ipw_tick_if.presc  tk
);
  logic [31:0] cyc_cnt;
  logic [5:0]  sec_cnt;
  logic        sec_end;

  assign sec_end = (cyc_cnt == 32'(CYCLES_PER_SEC - 1));

  // restart realigns the base so the first unit after a reload is whole
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_cnt <= 32'h0000_0000;
    end else if (tk.restart || sec_end) begin
      cyc_cnt <= 32'h0000_0000;
    end else begin
      cyc_cnt <= cyc_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt <= 6'h00;
    end else if (tk.restart) begin
      sec_cnt <= 6'h00;
    end else if (sec_end) begin
      if (sec_cnt == 6'(ipw_pkg::SECS_PER_MIN - 1)) begin
        sec_cnt <= 6'h00;
      end else begin
        sec_cnt <= sec_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tk.sec_tick <= 1'b0;
      tk.min_tick <= 1'b0;
    end else begin
      tk.sec_tick <= sec_end && !tk.restart;
      tk.min_tick <= sec_end && !tk.restart &&
                     (sec_cnt == 6'(ipw_pkg::SECS_PER_MIN - 1));
    end
  end
endmodule : ipw_prescaler
`default_nettype wire

// >>> rtl/ipw_watchdog.sv
// watchdog behind an index/data port pair with key-locked configuration
`timescale 1ns/1ps
`default_nettype none
module ipw_watchdog #(
  parameter int CYCLES_PER_SEC = ipw_pkg::CYCLES_PER_SEC
) (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic [15:0] IO_ADDR,
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  input  wire logic [7:0]  IO_WDATA,
  output var  logic [7:0]  IO_RDATA,
  input  wire logic        MOUSE_EVT,
  input  wire logic        KBD_EVT,
  input  wire logic        TIMEOUT_TO_RESET,
  output var  logic        WDT_IRQ,
  output var  logic        WDT_RESET
);
  ipw_tick_if tk ();

  localparam int N_SRC = 2;

  ipw_pkg::ipw_lock_t lock_state;
  ipw_pkg::ipw_lock_t next_lock_state;
  logic [7:0]  index;
  logic [7:0]  ldn;
  logic [7:0]  activate;
  logic [7:0]  unit_reg;
  logic [7:0]  load_val;
  logic [7:0]  count;
  logic [N_SRC-1:0] src_en;
  logic [N_SRC-1:0] src_evt;
  logic [N_SRC-1:0] src_hit;
  logic        timeout;
  logic        unlocked;
  logic        idx_wr;
  logic        dat_wr;
  logic        dat_rd;
  logic        wdt_sel;
  logic        enabled;
  logic        count_wr;
  logic        ctrl_wr;
  logic        ext_restart;
  logic        unit_tick;
  logic        expire;
  logic        force_to;
  logic [7:0]  rd_val;

  ipw_prescaler #(
    .CYCLES_PER_SEC (CYCLES_PER_SEC)
  ) u_presc (
    .clk   (CLOCK),
    .rst_n (RSTN),
    .tk    (tk)
  );

  assign unlocked = (lock_state == ipw_pkg::LK_UNLOCKED);
  assign idx_wr   = IO_WR && (IO_ADDR == ipw_pkg::INDEX_PORT);
  assign dat_wr   = IO_WR && (IO_ADDR == ipw_pkg::DATA_PORT) && unlocked;
  assign dat_rd   = IO_RD && (IO_ADDR == ipw_pkg::DATA_PORT) && unlocked;
  assign wdt_sel  = (ldn == ipw_pkg::LDN_WDT);
  assign enabled  = (activate == ipw_pkg::ACT_ENABLE);
  assign count_wr = dat_wr && wdt_sel && (index == ipw_pkg::REG_COUNT);
  assign ctrl_wr  = dat_wr && wdt_sel && (index == ipw_pkg::REG_CTRL);
  assign force_to = ctrl_wr && IO_WDATA[ipw_pkg::FORCE_BIT];

  // source 0 is the keyboard, source 1 the mouse, as in the control bits
  assign src_evt = {MOUSE_EVT, KBD_EVT};

  // external restarts reload only a running, not yet expired timer
  assign ext_restart = enabled && !timeout && (count != 8'h00) &&
                       (|src_hit);
  assign unit_tick = unit_reg[ipw_pkg::UNIT_BIT] ? tk.min_tick
                                                 : tk.sec_tick;
  assign expire    = enabled && unit_tick && (count == 8'h01) &&
                     !count_wr && !ext_restart;
  assign tk.restart = count_wr || ext_restart;

  always_comb begin
    next_lock_state = lock_state;
    case (lock_state)
      ipw_pkg::LK_LOCKED: begin
        if (idx_wr && IO_WDATA == ipw_pkg::KEY_UNLOCK) begin
          next_lock_state = ipw_pkg::LK_KEY1;
        end
      end
      ipw_pkg::LK_KEY1: begin
        if (idx_wr) begin
          next_lock_state = (IO_WDATA == ipw_pkg::KEY_UNLOCK) ?
                            ipw_pkg::LK_UNLOCKED : ipw_pkg::LK_LOCKED;
        end else if (IO_WR || IO_RD) begin
          next_lock_state = ipw_pkg::LK_LOCKED;
        end
      end
      ipw_pkg::LK_UNLOCKED: begin
        if (idx_wr && IO_WDATA == ipw_pkg::KEY_LOCK) begin
          next_lock_state = ipw_pkg::LK_LOCKED;
        end
      end
      default: begin
        next_lock_state = ipw_pkg::LK_LOCKED;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      lock_state <= ipw_pkg::LK_LOCKED;
    end else begin
      lock_state <= next_lock_state;
    end
  end

  // the lock key is a command, never a register number
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      index <= 8'h00;
    end else if (idx_wr && unlocked && IO_WDATA != ipw_pkg::KEY_LOCK) begin
      index <= IO_WDATA;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ldn <= ipw_pkg::RST_LDN;
    end else if (dat_wr && index == ipw_pkg::REG_LDN) begin
      ldn <= IO_WDATA;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      activate <= ipw_pkg::RST_ACTIVATE;
      unit_reg <= ipw_pkg::RST_UNIT;
    end else if (dat_wr && wdt_sel) begin
      if (index == ipw_pkg::REG_ACTIVATE) begin
        activate <= IO_WDATA;
      end
      if (index == ipw_pkg::REG_UNIT) begin
        unit_reg <= IO_WDATA;
      end
    end
  end

  // one enable flop per activity source, each fed by its own control bit
  for (genvar g = 0; g < N_SRC; g++) begin : g_src
    always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
        src_en[g] <= 1'b0;
      end else if (ctrl_wr) begin
        src_en[g] <= IO_WDATA[ipw_pkg::KBD_BIT + g];
      end
    end
    assign src_hit[g] = src_en[g] && src_evt[g];
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      load_val <= ipw_pkg::RST_COUNT;
    end else if (count_wr) begin
      load_val <= IO_WDATA;
    end
  end

  // a zero count never decrements, so zero holds the timer stopped
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      count <= ipw_pkg::RST_COUNT;
    end else if (count_wr) begin
      count <= IO_WDATA;
    end else if (ext_restart) begin
      count <= load_val;
    end else if (enabled && unit_tick && count != 8'h00) begin
      count <= count - 8'h01;
    end
  end

  // set beats clear, but a reload in the expiry cycle masks the expiry, so it is not reported
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      timeout <= 1'b0;
    end else if (expire || force_to) begin
      timeout <= 1'b1;
    end else if (count_wr || !enabled) begin
      timeout <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      WDT_IRQ   <= 1'b0;
      WDT_RESET <= 1'b0;
    end else begin
      WDT_IRQ   <= timeout && !TIMEOUT_TO_RESET;
      WDT_RESET <= timeout && TIMEOUT_TO_RESET;
    end
  end

  always_comb begin
    rd_val = ipw_pkg::RD_NONE;
    if (index == ipw_pkg::REG_LDN) begin
      rd_val = ldn;
    end else if (wdt_sel) begin
      case (index)
        ipw_pkg::REG_ACTIVATE: rd_val = activate;
        ipw_pkg::REG_UNIT:     rd_val = unit_reg;
        ipw_pkg::REG_COUNT:    rd_val = count;
        ipw_pkg::REG_CTRL: begin
          rd_val = ipw_pkg::RD_NONE;
          rd_val[ipw_pkg::MOUSE_BIT]  = src_en[1];
          rd_val[ipw_pkg::KBD_BIT]    = src_en[0];
          rd_val[ipw_pkg::STATUS_BIT] = timeout;
        end
        default: rd_val = ipw_pkg::RD_NONE;
      endcase
    end
  end

  // read data holds until the next data-port read
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      IO_RDATA <= ipw_pkg::RD_NONE;
    end else if (IO_RD && IO_ADDR == ipw_pkg::DATA_PORT) begin
      IO_RDATA <= dat_rd ? rd_val : ipw_pkg::RD_NONE;
    end
  end
endmodule : ipw_watchdog
`default_nettype wire

// >>> rtl/_unused.sv
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> verification/ipw_properties.sv
// port-level assertions for the indexed-port watchdog
`timescale 1ns/1ps
`default_nettype none
module ipw_properties #(
  parameter int CYCLES_PER_SEC = 10
) (
  input wire logic        CLOCK,
  input wire logic        RSTN,
  input wire logic [15:0] IO_ADDR,
  input wire logic        IO_WR,
  input wire logic        IO_RD,
  input wire logic [7:0]  IO_WDATA,
  input wire logic [7:0]  IO_RDATA,
  input wire logic        MOUSE_EVT,
  input wire logic        KBD_EVT,
  input wire logic        TIMEOUT_TO_RESET,
  input wire logic        WDT_IRQ,
  input wire logic        WDT_RESET
);
  logic [3:0] since_rst;
  logic       rd_dat;
  assign rd_dat = IO_RD && (IO_ADDR == ipw_pkg::DATA_PORT);
  // counts edges since reset; no timeout can be reached this early
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) since_rst <= 4'h0;
    else if (since_rst != 4'hf) since_rst <= since_rst + 4'h1;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  AST_ONE_OUT: assert property (!(WDT_IRQ && WDT_RESET))
    else $error("both timeout outputs high");
  AST_IRQ_ROUTE: assert property (WDT_IRQ |-> !$past(TIMEOUT_TO_RESET))
    else $error("interrupt raised while routed to reset");
  AST_RST_ROUTE: assert property (WDT_RESET |-> $past(TIMEOUT_TO_RESET))
    else $error("reset raised while routed to interrupt");
  // a disabling write drops the outputs two edges after it is taken
  AST_IRQ_STANDS: assert property (WDT_IRQ && !TIMEOUT_TO_RESET && !IO_WR
    && !$past(IO_WR) && !$past(IO_WR, 2) |=> WDT_IRQ)
    else $error("interrupt dropped alone");
  AST_RST_STANDS: assert property (WDT_RESET && TIMEOUT_TO_RESET && !IO_WR
    && !$past(IO_WR) && !$past(IO_WR, 2) |=> WDT_RESET)
    else $error("reset dropped alone");
  AST_RDATA_HOLD: assert property (!rd_dat |=> $stable(IO_RDATA))
    else $error("read data moved without a data read");
  AST_QUIET_OUT: assert property (since_rst < 4'h6 |-> !WDT_IRQ && !WDT_RESET)
    else $error("timeout output right after reset");
  AST_QUIET_RD: assert property (since_rst < 4'h3 |-> IO_RDATA == 8'h00)
    else $error("locked read returned data");
endmodule : ipw_properties
`default_nettype wire

// >>> verification/ipw_host.sv
// host software model driving the index/data port pair
`timescale 1ns/1ps
`default_nettype none
module ipw_host (
  input  wire logic        clk,
  output var  logic [15:0] addr,
  output var  logic        wr,
  output var  logic        rd,
  output var  logic [7:0]  wdata,
  output var  logic        mouse,
  output var  logic        kbd,
  input  wire logic [7:0]  rdata
);
  initial begin
    addr = 16'h0000; wr = 1'b0; rd = 1'b0; wdata = 8'h00;
    mouse = 1'b0; kbd = 1'b0;
  end
  task automatic iow(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(negedge clk);
    // released lines flip so a stale value is never mistaken for data
    addr <= ~a; wdata <= ~d; wr <= 1'b0;
  endtask : iow
  task automatic ior(output logic [7:0] d);
    @(negedge clk);
    addr <= ipw_pkg::DATA_PORT; rd <= 1'b1;
    @(negedge clk);
    addr <= ~ipw_pkg::DATA_PORT; rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : ior
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    iow(ipw_pkg::INDEX_PORT, i);
    iow(ipw_pkg::DATA_PORT, d);
  endtask : wreg
  task automatic rreg(input logic [7:0] i, output logic [7:0] d);
    iow(ipw_pkg::INDEX_PORT, i);
    ior(d);
  endtask : rreg
  task automatic unlock;
    iow(ipw_pkg::INDEX_PORT, ipw_pkg::KEY_UNLOCK);
    iow(ipw_pkg::INDEX_PORT, ipw_pkg::KEY_UNLOCK);
    wreg(ipw_pkg::REG_LDN, ipw_pkg::LDN_WDT);
  endtask : unlock
  task automatic lock;
    iow(ipw_pkg::INDEX_PORT, ipw_pkg::KEY_LOCK);
  endtask : lock
  task automatic pulse(input logic k);
    @(negedge clk);
    if (k) kbd <= 1'b1;
    else mouse <= 1'b1;
    @(negedge clk);
    kbd <= 1'b0; mouse <= 1'b0;
  endtask : pulse
endmodule : ipw_host
`default_nettype wire

// >>> verification/ipw_watchdog_tb.sv
// self-checking bench for the indexed-port watchdog
`timescale 1ns/1ps
`default_nettype none
module ipw_watchdog_tb;
  localparam int CPS = 10;
  localparam logic [7:0] R_IDX [6] = '{8'hf0,8'hf0,8'hf2,8'hf2,8'h30,8'h07};
  localparam logic [7:0] R_DAT [6] = '{8'h08,8'h00,8'hd0,8'h00,8'h01,8'h08};
  localparam logic [7:0] R_EXP [6] = '{8'h08,8'h00,8'hc0,8'h00,8'h01,8'h08};
  logic        clk, rstn, to_rst, wr, rd, mouse, kbd, irq, wrst;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, got;
  int          err_total, checks_done, k;
  ipw_watchdog #(.CYCLES_PER_SEC(CPS)) dut (.CLOCK(clk), .RSTN(rstn),
    .IO_ADDR(addr), .IO_WR(wr), .IO_RD(rd), .IO_WDATA(wdata),
    .IO_RDATA(rdata), .MOUSE_EVT(mouse), .KBD_EVT(kbd),
    .TIMEOUT_TO_RESET(to_rst), .WDT_IRQ(irq), .WDT_RESET(wrst));
  ipw_host u_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd),
    .wdata(wdata), .mouse(mouse), .kbd(kbd), .rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // bounded wait for either timeout output, in cycles
  task automatic wait_out(output int n);
    n = 0;
    while (!(irq === 1'b1 || wrst === 1'b1)) begin
      @(negedge clk);
      n++;
      if (n > 2000) begin
        err_total++;
        summarize();
      end
    end
  endtask : wait_out
  initial begin
    err_total = 0; checks_done = 0; rstn = 1'b0; to_rst = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    u_host.iow(ipw_pkg::DATA_PORT, 8'h55);
    u_host.ior(got);
    chk(16'(got), 16'h0000);
    chk(16'({irq, wrst}), 16'h0000);
    $display("test reset done");
    u_host.unlock();
    u_host.rreg(ipw_pkg::REG_COUNT, got);
    chk(16'(got), 16'h0000);
    for (int i = 0; i < 6; i++) begin
      u_host.wreg(R_IDX[i], R_DAT[i]);
      u_host.rreg(R_IDX[i], got);
      chk(16'(got), 16'(R_EXP[i]));
    end
    repeat (30) @(negedge clk);
    chk(16'({irq, wrst}), 16'h0000);
    $display("test rows done");
    u_host.wreg(ipw_pkg::REG_COUNT, 8'h03);
    wait_out(k);
    chk(16'(k), 16'(3 * CPS + 2));
    chk(16'({irq, wrst}), 16'h0002);
    u_host.rreg(ipw_pkg::REG_CTRL, got);
    chk(16'(got), 16'h0010);
    u_host.rreg(ipw_pkg::REG_COUNT, got);
    chk(16'(got), 16'h0000);
    u_host.wreg(ipw_pkg::REG_COUNT, 8'h02);
    repeat (15) @(negedge clk);
    u_host.wreg(ipw_pkg::REG_COUNT, 8'h02);
    wait_out(k);
    chk(16'(k), 16'(2 * CPS + 2));
    $display("test count done");
    // an event late in the interval must push the timeout well out
    for (int i = 0; i < 2; i++) begin
      u_host.wreg(ipw_pkg::REG_CTRL, (i == 1) ? 8'h40 : 8'h80);
      u_host.wreg(ipw_pkg::REG_COUNT, 8'h02);
      repeat (15) @(negedge clk);
      u_host.pulse(i[0]);
      wait_out(k);
      chk(16'(k > 12), 16'h0001);
    end
    $display("test restart done");
    u_host.wreg(ipw_pkg::REG_COUNT, 8'h00);
    to_rst = 1'b1;
    u_host.wreg(ipw_pkg::REG_UNIT, 8'h08);
    u_host.wreg(ipw_pkg::REG_COUNT, 8'h01);
    wait_out(k);
    chk(16'(k), 16'(ipw_pkg::SECS_PER_MIN * CPS + 2));
    chk(16'({irq, wrst}), 16'h0001);
    $display("test minutes done");
    u_host.wreg(ipw_pkg::REG_COUNT, 8'h00);
    u_host.wreg(ipw_pkg::REG_CTRL, 8'h20);
    wait_out(k);
    chk(16'(k), 16'h0001);
    u_host.rreg(ipw_pkg::REG_CTRL, got);
    chk(16'(got), 16'h0010);
    u_host.wreg(ipw_pkg::REG_ACTIVATE, 8'h00);
    repeat (3) @(negedge clk);
    chk(16'({irq, wrst}), 16'h0000);
    $display("test force done");
    u_host.lock();
    u_host.rreg(ipw_pkg::REG_LDN, got);
    chk(16'(got), 16'h0000);
    // any access between the two keys must throw the first one away
    u_host.iow(ipw_pkg::INDEX_PORT, ipw_pkg::KEY_UNLOCK);
    u_host.iow(ipw_pkg::DATA_PORT, 8'h55);
    u_host.iow(ipw_pkg::INDEX_PORT, ipw_pkg::KEY_UNLOCK);
    u_host.rreg(ipw_pkg::REG_LDN, got);
    chk(16'(got), 16'h0000);
    $display("test lock done");
    summarize();
  end
endmodule : ipw_watchdog_tb
bind ipw_watchdog ipw_properties #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) u_props (
  .CLOCK(CLOCK), .RSTN(RSTN), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
  .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
  .MOUSE_EVT(MOUSE_EVT), .KBD_EVT(KBD_EVT),
  .TIMEOUT_TO_RESET(TIMEOUT_TO_RESET), .WDT_IRQ(WDT_IRQ),
  .WDT_RESET(WDT_RESET));
`default_nettype wire
